// [logic/bisq_pkg.sv]
// Purpose: Shared constants and types of the burner ignition sequencer
// Assumes: 100 MHz clock, settings counted in whole seconds
// Notes: Temperatures are in degrees Fahrenheit
package bisq_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int SECOND_NS = 1000000000;
  localparam int SECOND_CYCLES = SECOND_NS / CLOCK_PERIOD_NS;
  localparam logic [10:0] TIMER_SAT = 11'h7FF;
  localparam logic [1:0] FLAME_SAT = 2'h3;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ACTIVE = 4'h8;
  localparam logic [3:0] REG_EDITOR = 4'hC;
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_CLEAR_BIT = 2;

  // ----------------------------------------
  // Settings list
  // ----------------------------------------
  localparam logic [3:0] ITEM_MODE = 4'h0;
  localparam logic [3:0] ITEM_PRE_PURGE = 4'h1;
  localparam logic [3:0] ITEM_TRIAL = 4'h2;
  localparam logic [3:0] ITEM_PURGE = 4'h3;
  localparam logic [3:0] ITEM_WAIT = 4'h4;
  localparam logic [3:0] ITEM_IGN_RETRY = 4'h5;
  localparam logic [3:0] ITEM_WAIT_RETRY = 4'h6;
  localparam logic [3:0] ITEM_PROVE = 4'h7;
  localparam logic [3:0] ITEM_DEMAND = 4'h8;
  localparam logic [3:0] ITEM_TEMP = 4'h9;
  localparam logic [3:0] ITEM_APPLY = 4'hA;
  localparam logic [3:0] VIEW_ROWS = 4'h4;
  localparam logic [3:0] VIEW_LAST = 4'h3;

  // ----------------------------------------
  // Setting limits
  // ----------------------------------------
  localparam logic [11:0] VAL_ZERO = 12'h000;
  localparam logic [11:0] VAL_ONE = 12'h001;
  localparam logic [11:0] PRE_PURGE_MAX = 12'h258;
  localparam logic [11:0] TRIAL_MIN = 12'h001;
  localparam logic [11:0] TRIAL_MAX = 12'h03C;
  localparam logic [11:0] PURGE_MAX = 12'h00A;
  localparam logic [11:0] WAIT_MAX = 12'h708;
  localparam logic [11:0] RETRY_MAX = 12'h003;
  localparam logic [11:0] PROVE_MAX = 12'h003;
  localparam logic [11:0] TEMP_MIN = 12'h064;
  localparam logic [11:0] TEMP_MAX = 12'h99C;

  typedef struct packed {
    logic manual;
    logic [9:0] pre_purge;
    logic [5:0] trial;
    logic [3:0] purge;
    logic [10:0] wait_s;
    logic [1:0] ign_retry;
    logic [1:0] wait_retry;
    logic [1:0] prove;
    logic demand;
    logic [11:0] temp_limit;
  } bisq_cfg_t;

  localparam bisq_cfg_t CFG_DEFAULT = '{manual: 1'b0, pre_purge: 10'h005, trial: 6'h1E, purge: 4'hA,
    wait_s: 11'h000, ign_retry: 2'h2, wait_retry: 2'h2, prove: 2'h3, demand: 1'b0, temp_limit: 12'h640};

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_PREPURGE = 7'h02,
    ST_TRIAL = 7'h04,
    ST_PURGE = 7'h08,
    ST_WAIT = 7'h10,
    ST_LIT = 7'h20,
    ST_LOCKOUT = 7'h40
  } bisq_state_t;
endpackage : bisq_pkg

// [logic/bisq_reg_if.sv]
// Purpose: Register access between bus slave and sequencer core
// Assumes: One access per data phase
// Notes: addr holds the latched address through the data phase
`timescale 1ns/1ps
interface bisq_reg_if;
  logic wr_en;
  logic [3:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport bus (output wr_en, output addr, output wdata, input rdata);
  modport core (input wr_en, input addr, input wdata, output rdata);
endinterface : bisq_reg_if

// [logic/bisq_ahb_slave.sv]
// Purpose: Zero-wait AHB-Lite slave for the sequencer registers
// Assumes: Single word transfers only
// Notes: Unmapped addresses read zero, writes are dropped, response OKAY
`timescale 1ns/1ps
module bisq_ahb_slave
  import bisq_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // AHB-Lite
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Core side
  bisq_reg_if.bus regs
);
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] addr;
  } bisq_ahb_t;

  bisq_ahb_t s_reg;
  bisq_ahb_t s_next;

  always_comb begin
    s_next = '0;
    if (i_hsel && i_htrans[1] && i_hready) begin
      s_next.valid = (i_haddr[31:4] == 28'h0000000) && (i_haddr[1:0] == 2'h0);
      s_next.write = i_hwrite;
      s_next.addr = i_haddr[3:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign regs.wr_en = s_reg.valid && s_reg.write;
  assign regs.addr = s_reg.addr;
  assign regs.wdata = i_hwdata;
  assign o_hrdata = (s_reg.valid && !s_reg.write) ? regs.rdata : 32'h00000000;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
endmodule : bisq_ahb_slave

// [logic/bisq_tick.sv]
// Purpose: One-second enable pulse
// Assumes: CYCLES is the clock count of one second
// Notes: Pulse lasts one clock
`timescale 1ns/1ps
module bisq_tick #(
  parameter int CYCLES = 100000000
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Pulse
  output logic o_tick
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  typedef struct packed {
    logic [W-1:0] count;
    logic tick;
  } bisq_tick_t;

  bisq_tick_t t_reg;
  bisq_tick_t t_next;

  always_comb begin
    t_next = t_reg;
    t_next.tick = 1'b0;
    if (t_reg.count == W'(CYCLES - 1)) begin
      t_next.count = '0;
      t_next.tick = 1'b1;
    end else begin
      t_next.count = t_reg.count + W'(1);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign o_tick = t_reg.tick;
endmodule : bisq_tick

// [logic/bisq_sequencer.sv]
// Purpose: Pilot ignition sequencer with keypad settings editor
// Assumes: Keys are one-cycle pulses, temperatures in degrees F
// Notes: Registers over AHB-Lite; see package for the map
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Automatic or manual mode, automatic by default
// - Automatic mode relights after flame loss
// - Manual mode never relights by itself
// - Pre-purge 0 to 600 s, default 5
// - Spark trial 1 to 60 s, default 30
// - Purge between trials 0 to 10 s
// - Retry wait 0 to 1800 s, default 0
// - Trial retries 0 to 3, default 2
// - Wait retries 0 to 3
// - Pilot lit after uninterrupted flame proving time
// - Demand pilot option, default off, automatic only
// - Demand off: pilot stays lit while active
// - Demand on: light when any process active
// - Demand on, no process: pilot off
// - Independent process never counts as demand
// - Lockout when thermocouple reaches temperature limit
// - Edits adopted only after apply and yes
// - Up/down move cursor, left/right change value
// - List shown four rows at a time
module bisq_sequencer
  import bisq_pkg::*;
#(
  parameter int SECOND_TICKS = SECOND_CYCLES
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // AHB-Lite register bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Keypad
  input wire logic i_key_up,
  input wire logic i_key_down,
  input wire logic i_key_left,
  input wire logic i_key_right,
  input wire logic i_key_ok,
  // Burner side
  input wire logic i_flame,
  input wire logic [11:0] i_tc1_temp,
  input wire logic [11:0] i_tc2_temp,
  input wire logic [2:0] i_process_active,
  input wire logic i_indep_active,
  output logic o_pilot_valve,
  output logic o_igniter,
  output logic o_purge,
  output logic o_lockout,
  // Display
  output logic [3:0] o_cursor,
  output logic [3:0] o_view_top,
  output logic o_confirm,
  output logic o_confirm_yes
);
  typedef struct packed {
    bisq_state_t state;
    logic [10:0] timer;
    logic [1:0] flame_cnt;
    logic [1:0] ign_cnt;
    logic [1:0] wait_cnt;
    logic hot;
    logic sys_active;
    logic pilot;
    logic igniter;
    logic purge;
    logic lockout;
    bisq_cfg_t active;
    bisq_cfg_t pending;
    logic [3:0] cursor;
    logic [3:0] view;
    logic confirm;
    logic yes;
  } bisq_core_t;

  localparam bisq_core_t CORE_RESET = '{state: ST_IDLE, active: CFG_DEFAULT, pending: CFG_DEFAULT,
    default: '0};

  bisq_core_t r;
  bisq_core_t n;
  bisq_reg_if regs ();
  logic tick;
  logic hot_now;
  logic want;
  logic proven;
  logic timer_done;
  logic start_cmd;
  logic clear_cmd;
  logic commit;
  logic [11:0] v;

  // ----------------------------------------
  // Setting access
  // ----------------------------------------
  function automatic logic [11:0] item_val(bisq_cfg_t c, logic [3:0] i);
    case (i)
      ITEM_MODE: item_val = {11'h000, c.manual};
      ITEM_PRE_PURGE: item_val = {2'h0, c.pre_purge};
      ITEM_TRIAL: item_val = {6'h00, c.trial};
      ITEM_PURGE: item_val = {8'h00, c.purge};
      ITEM_WAIT: item_val = {1'b0, c.wait_s};
      ITEM_IGN_RETRY: item_val = {10'h000, c.ign_retry};
      ITEM_WAIT_RETRY: item_val = {10'h000, c.wait_retry};
      ITEM_PROVE: item_val = {10'h000, c.prove};
      ITEM_DEMAND: item_val = {11'h000, c.demand};
      ITEM_TEMP: item_val = c.temp_limit;
      default: item_val = VAL_ZERO;
    endcase
  endfunction : item_val

  function automatic logic [11:0] item_min(logic [3:0] i);
    case (i)
      ITEM_TRIAL: item_min = TRIAL_MIN;
      ITEM_TEMP: item_min = TEMP_MIN;
      default: item_min = VAL_ZERO;
    endcase
  endfunction : item_min

  function automatic logic [11:0] item_max(logic [3:0] i);
    case (i)
      ITEM_PRE_PURGE: item_max = PRE_PURGE_MAX;
      ITEM_TRIAL: item_max = TRIAL_MAX;
      ITEM_PURGE: item_max = PURGE_MAX;
      ITEM_WAIT: item_max = WAIT_MAX;
      ITEM_IGN_RETRY: item_max = RETRY_MAX;
      ITEM_WAIT_RETRY: item_max = RETRY_MAX;
      ITEM_PROVE: item_max = PROVE_MAX;
      ITEM_TEMP: item_max = TEMP_MAX;
      default: item_max = VAL_ONE;
    endcase
  endfunction : item_max

  function automatic bisq_cfg_t item_set(bisq_cfg_t c, logic [3:0] i, logic [11:0] x);
    item_set = c;
    case (i)
      ITEM_MODE: item_set.manual = x[0];
      ITEM_PRE_PURGE: item_set.pre_purge = x[9:0];
      ITEM_TRIAL: item_set.trial = x[5:0];
      ITEM_PURGE: item_set.purge = x[3:0];
      ITEM_WAIT: item_set.wait_s = x[10:0];
      ITEM_IGN_RETRY: item_set.ign_retry = x[1:0];
      ITEM_WAIT_RETRY: item_set.wait_retry = x[1:0];
      ITEM_PROVE: item_set.prove = x[1:0];
      ITEM_DEMAND: item_set.demand = x[0];
      ITEM_TEMP: item_set.temp_limit = x;
      default: item_set = c;
    endcase
  endfunction : item_set

  function automatic logic [10:0] state_dur(bisq_state_t s, bisq_cfg_t c);
    case (s)
      ST_PREPURGE: state_dur = {1'b0, c.pre_purge};
      ST_TRIAL: state_dur = {5'h00, c.trial};
      ST_PURGE: state_dur = {7'h00, c.purge};
      ST_WAIT: state_dur = c.wait_s;
      default: state_dur = 11'h000;
    endcase
  endfunction : state_dur

  // ----------------------------------------
  // Bus and timebase
  // ----------------------------------------
  bisq_ahb_slave u_ahb (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .regs(regs.bus)
  );

  bisq_tick #(.CYCLES(SECOND_TICKS)) u_tick (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .o_tick(tick)
  );

  always_comb begin
    case (regs.addr)
      REG_CTRL: regs.rdata = {31'h00000000, r.sys_active};
      REG_STATUS: regs.rdata = {22'h000000, i_indep_active, i_flame, r.hot, r.state};
      REG_ACTIVE: regs.rdata = {12'h000, r.active.temp_limit, r.active.demand, r.active.prove,
        r.active.wait_retry, r.active.ign_retry, r.active.manual};
      REG_EDITOR: regs.rdata = {22'h000000, r.yes, r.confirm, r.view, r.cursor};
      default: regs.rdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign start_cmd = regs.wr_en && (regs.addr == REG_CTRL) && regs.wdata[CTRL_START_BIT];
  assign clear_cmd = regs.wr_en && (regs.addr == REG_CTRL) && regs.wdata[CTRL_CLEAR_BIT];
  assign hot_now = (i_tc1_temp >= r.active.temp_limit) || (i_tc2_temp >= r.active.temp_limit);
  // Independent process is not part of the demand term
  assign want = r.sys_active && (r.active.manual || !r.active.demand || (|i_process_active));
  assign proven = i_flame && (r.flame_cnt >= r.active.prove);
  assign timer_done = r.timer >= state_dur(r.state, r.active);
  assign commit = r.confirm && r.yes && i_key_ok;
  assign v = item_val(r.pending, r.cursor);

  always_comb begin
    n = r;
    if (regs.wr_en && (regs.addr == REG_CTRL)) begin
      n.sys_active = regs.wdata[CTRL_ACTIVE_BIT];
    end
    if (tick && (r.timer != TIMER_SAT)) begin
      n.timer = r.timer + 11'h001;
    end
    if (!i_flame) begin
      n.flame_cnt = 2'h0;
    end else if (tick && (r.flame_cnt != FLAME_SAT)) begin
      n.flame_cnt = r.flame_cnt + 2'h1;
    end
    unique case (r.state)
      ST_IDLE: begin
        n.ign_cnt = 2'h0;
        n.wait_cnt = 2'h0;
        if (want && (!r.active.manual || start_cmd)) begin
          n.state = ST_PREPURGE;
        end
      end
      ST_PREPURGE: begin
        if (timer_done) begin
          n.state = ST_TRIAL;
        end
      end
      ST_TRIAL: begin
        if (proven) begin
          n.state = ST_LIT;
        end else if (timer_done) begin
          if (r.ign_cnt < r.active.ign_retry) begin
            n.ign_cnt = r.ign_cnt + 2'h1;
            n.state = ST_PURGE;
          end else if (r.wait_cnt < r.active.wait_retry) begin
            n.wait_cnt = r.wait_cnt + 2'h1;
            n.ign_cnt = 2'h0;
            n.state = ST_WAIT;
          end else begin
            n.state = ST_LOCKOUT;
          end
        end
      end
      ST_PURGE: begin
        if (timer_done) begin
          n.state = ST_TRIAL;
        end
      end
      ST_WAIT: begin
        if (timer_done) begin
          n.state = ST_PREPURGE;
        end
      end
      ST_LIT: begin
        if (!i_flame) begin
          n.ign_cnt = 2'h0;
          n.wait_cnt = 2'h0;
          n.state = r.active.manual ? ST_IDLE : ST_PREPURGE;
        end
      end
      ST_LOCKOUT: begin
        if (clear_cmd && !hot_now) begin
          n.state = ST_IDLE;
        end
      end
    endcase
    // Loss of demand or system stop shuts the pilot down
    if (!want && (r.state != ST_LOCKOUT)) begin
      n.state = ST_IDLE;
    end
    // Over-temperature overrides everything; set wins over clear
    if (clear_cmd) begin
      n.hot = 1'b0;
    end
    if (hot_now) begin
      n.hot = 1'b1;
      n.state = ST_LOCKOUT;
    end
    if (n.state != r.state) begin
      n.timer = 11'h000;
    end
    n.pilot = (n.state == ST_TRIAL) || (n.state == ST_LIT);
    n.igniter = (n.state == ST_TRIAL);
    n.purge = (n.state == ST_PREPURGE) || (n.state == ST_PURGE);
    n.lockout = (n.state == ST_LOCKOUT);

    // Settings editor
    if (r.confirm) begin
      if (i_key_left || i_key_right) begin
        n.yes = !r.yes;
      end
      if (i_key_ok) begin
        n.confirm = 1'b0;
        if (r.yes) begin
          n.active = r.pending;
        end
      end
    end else begin
      if (i_key_up && (r.cursor != ITEM_MODE)) begin
        n.cursor = r.cursor - 4'h1;
      end else if (i_key_down && (r.cursor != ITEM_APPLY)) begin
        n.cursor = r.cursor + 4'h1;
      end
      if (i_key_ok && (r.cursor == ITEM_APPLY)) begin
        n.confirm = 1'b1;
        n.yes = 1'b0;
      end
      if (i_key_right && (v < item_max(r.cursor))) begin
        n.pending = item_set(r.pending, r.cursor, v + VAL_ONE);
      end else if (i_key_left && (v > item_min(r.cursor))) begin
        n.pending = item_set(r.pending, r.cursor, v - VAL_ONE);
      end
    end
    if (n.cursor < r.view) begin
      n.view = n.cursor;
    end else if (n.cursor > (r.view + VIEW_LAST)) begin
      n.view = n.cursor - VIEW_LAST;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      r <= CORE_RESET;
    end else begin
      r <= n;
    end
  end

  assign o_pilot_valve = r.pilot;
  assign o_igniter = r.igniter;
  assign o_purge = r.purge;
  assign o_lockout = r.lockout;
  assign o_cursor = r.cursor;
  assign o_view_top = r.view;
  assign o_confirm = r.confirm;
  assign o_confirm_yes = r.yes;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_temp_lockout: assert property (hot_now |=> (r.state == ST_LOCKOUT) && r.hot && o_lockout)
    else $error("over-temperature did not lock out");
  a_manual_hold: assert property ((r.state == ST_LIT) && !i_flame && r.active.manual && !hot_now
    |=> (r.state == ST_IDLE) ##1 ((r.state == ST_IDLE) || $past(start_cmd) || $past(hot_now)))
    else $error("manual mode relit without command");
  a_auto_relight: assert property ((r.state == ST_LIT) && !i_flame && !r.active.manual && want && !hot_now
    |=> (r.state == ST_PREPURGE) && !o_pilot_valve)
    else $error("automatic mode did not relight");
  a_proof_time: assert property ($rose(r.state == ST_LIT)
    |-> $past(i_flame) && ($past(r.flame_cnt) >= $past(r.active.prove)))
    else $error("pilot lit without proven flame");
  a_demand_drop: assert property ((r.state == ST_LIT) && !r.active.manual && r.active.demand
    && (i_process_active == 3'h0) && !hot_now |=> (r.state == ST_IDLE) && !o_pilot_valve)
    else $error("pilot kept lit without demand");
  a_indep_ignored: assert property ((r.state == ST_IDLE) && !r.active.manual && r.active.demand
    && (i_process_active == 3'h0) |=> (r.state != ST_PREPURGE))
    else $error("pilot started without linked demand");
  a_commit_gate: assert property ($changed(r.active) |-> $past(commit))
    else $error("settings adopted without confirmation");
  a_view_rows: assert property ((r.cursor >= r.view) && (r.cursor < (r.view + VIEW_ROWS)))
    else $error("cursor outside four-row view");
  a_pending_range: assert property ((r.pending.trial >= 6'h01) && (r.pending.trial <= 6'h3C)
    && (r.pending.pre_purge <= 10'h258) && (r.pending.purge <= 4'hA) && (r.pending.wait_s <= 11'h708)
    && (r.pending.temp_limit >= 12'h064) && (r.pending.temp_limit <= 12'h99C))
    else $error("pending setting out of range");
  a_exhaust_lock: assert property ((r.state == ST_TRIAL) && timer_done && !proven && want
    && (r.ign_cnt >= r.active.ign_retry) && (r.wait_cnt >= r.active.wait_retry) |=> (r.state == ST_LOCKOUT))
    else $error("retries exhausted without lockout");

  c_lit: cover property ((r.state == ST_TRIAL) ##1 (r.state == ST_LIT));
  c_relight: cover property ((r.state == ST_LIT) ##1 (r.state == ST_PREPURGE));
  c_lockout: cover property ((r.state == ST_TRIAL) ##1 (r.state == ST_LOCKOUT));
  c_commit: cover property (commit);
endmodule : bisq_sequencer

// [sim/bisq_burner_model.sv]
// Purpose: Behavioural burner: flame sensor and thermocouples
// Assumes: Flame shows once the spark has run a few cycles
// Notes: Bench decides whether lighting works and when it runs hot
`timescale 1ns/1ps
module bisq_burner_model
  import bisq_pkg::*;
#(
  parameter int LIGHT_CYCLES = 6
) (
  // Clock
  input wire logic i_clock,
  // Bench commands
  input wire logic i_light_ok,
  input wire logic i_hot,
  input wire logic [11:0] i_cool,
  // From sequencer
  input wire logic i_pilot_valve,
  input wire logic i_igniter,
  // To sequencer
  output logic o_flame,
  output logic [11:0] o_tc1_temp,
  output logic [11:0] o_tc2_temp
);
  int spark_cycles = 0;
  initial o_flame = 1'b0;
  // Flame dies as soon as gas is cut or lighting is disabled
  always @(posedge i_clock) begin
    spark_cycles <= (i_pilot_valve && i_igniter) ? spark_cycles + 1 : 0;
    if (!i_pilot_valve || !i_light_ok) begin
      o_flame <= 1'b0;
    end else if (spark_cycles >= LIGHT_CYCLES) begin
      o_flame <= 1'b1;
    end
  end
  // Channel two trips the limit alone
  assign o_tc1_temp = i_cool;
  assign o_tc2_temp = i_hot ? CFG_DEFAULT.temp_limit : i_cool;
endmodule : bisq_burner_model

// [sim/bisq_sequencer_test.sv]
// Purpose: Self-checking bench of the ignition sequencer
// Assumes: Zero-wait bus, four clocks per second
// Notes: Reads are queued as notes and judged by the monitor
`timescale 1ns/1ps
module bisq_sequencer_test;
  import bisq_pkg::*;
  localparam int TICKS = 4;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [4:0] keys = '0;
  logic [2:0] proc = '0;
  logic indep = 1'b1;
  logic light_ok = 1'b0;
  logic hot = 1'b0;
  logic [11:0] cool = 12'h100;
  logic dchk = 1'b0;
  logic flame, hreadyout, pilot, igniter, ign_d;
  logic [11:0] tc1, tc2;
  logic [31:0] hrdata, rd;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 6814;
  int sparks = 0;

  always #5 i_clock = ~i_clock;

  bisq_sequencer #(.SECOND_TICKS(TICKS)) bisq_sequencer_i (
    .i_clock(i_clock), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hreadyout), .i_hwdata(hwdata), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(), .i_key_up(keys[0]), .i_key_down(keys[1]),
    .i_key_left(keys[2]), .i_key_right(keys[3]), .i_key_ok(keys[4]), .i_flame(flame),
    .i_tc1_temp(tc1), .i_tc2_temp(tc2), .i_process_active(proc), .i_indep_active(indep),
    .o_pilot_valve(pilot), .o_igniter(igniter), .o_purge(), .o_lockout(), .o_cursor(),
    .o_view_top(), .o_confirm(), .o_confirm_yes());

  bisq_burner_model bisq_burner_model_i (
    .i_clock(i_clock), .i_light_ok(light_ok), .i_hot(hot), .i_cool(cool), .i_pilot_valve(pilot),
    .i_igniter(igniter), .o_flame(flame), .o_tc1_temp(tc1), .o_tc2_temp(tc2));

  task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
    samples_checked++;
    if (got !== expv) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, expv, got);
    end
  endtask : check

  // ----------------------------------------
  // Monitor
  // ----------------------------------------
  always @(posedge i_clock) begin
    ign_d <= igniter;
    if (igniter === 1'b1 && ign_d === 1'b0) begin
      sparks++;
    end
    if (dchk) begin
      check("hrdata", exp_q.pop_front(), hrdata & mask_q.pop_front());
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic chk);
    @(posedge i_clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge i_clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dchk <= chk;
    do @(posedge i_clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    dchk <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    bus(1'b0, a, '0, 1'b1);
  endtask : rd_chk

  task automatic press(input int k, input int n);
    repeat (n) begin
      @(posedge i_clock);
      keys <= 5'(1 << k);
      @(posedge i_clock);
      keys <= '0;
    end
  endtask : press

  task automatic wait_state(input logic [31:0] e, input logic [31:0] m, input int polls);
    rd = '0;
    for (int n = 0; n < polls && (rd & m) !== e; n++) begin
      bus(1'b0, 32'(REG_STATUS), '0, 1'b0);
    end
    rd_chk(32'(REG_STATUS), e, m);
  endtask : wait_state

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    cool <= 12'h100 + 12'($random(seed) & 32'h3FF);
    rd_chk(32'(REG_ACTIVE), 32'h00064074, 32'hFFFFFFFF);
    rd_chk(32'h10, 32'h0, 32'hFFFFFFFF);
    press(1, 5);
    press(3, 2);
    press(1, 3);
    press(3, 1);
    press(1, 2);
    rd_chk(32'(REG_EDITOR), 32'h7A, 32'h3FF);
    press(4, 2);
    rd_chk(32'(REG_ACTIVE), 32'h00064074, 32'hFFFFFFFF);
    press(4, 1);
    press(3, 1);
    press(4, 1);
    rd_chk(32'(REG_ACTIVE), 32'h000640F6, 32'hFFFFFFFF);
    bus(1'b1, 32'(REG_CTRL), 32'h1, 1'b0);
    bus(1'b1, 32'(REG_STATUS), 32'hFF, 1'b0);
    repeat (20) @(posedge i_clock);
    rd_chk(32'(REG_STATUS), 32'h201, 32'h27F);
    proc <= 3'($random(seed)) | 3'h1;
    wait_state(32'h02, 32'h7F, 100);
    light_ok <= 1'b1;
    wait_state(32'h20, 32'h7F, 200);
    proc <= 3'h0;
    wait_state(32'h01, 32'h7F, 50);
    check("pilot", 32'h0, 32'(pilot));
    proc <= 3'h2;
    wait_state(32'h20, 32'h7F, 200);
    light_ok <= 1'b0;
    wait_state(32'h02, 32'h7F, 50);
    proc <= 3'h0;
    wait_state(32'h01, 32'h7F, 50);
    sparks = 0;
    proc <= 3'h4;
    wait_state(32'h40, 32'h7F, 1500);
    check("sparks", 32'd12, 32'(sparks));
    // Switch to manual mode through the editor
    press(0, 10);
    press(3, 1);
    press(1, 10);
    press(4, 1);
    press(3, 1);
    press(4, 1);
    rd_chk(32'(REG_ACTIVE), 32'h000640F7, 32'hFFFFFFFF);
    light_ok <= 1'b1;
    bus(1'b1, 32'(REG_CTRL), 32'h5, 1'b0);
    repeat (20) @(posedge i_clock);
    rd_chk(32'(REG_STATUS), 32'h01, 32'h7F);
    bus(1'b1, 32'(REG_CTRL), 32'h3, 1'b0);
    wait_state(32'h20, 32'h7F, 200);
    light_ok <= 1'b0;
    wait_state(32'h01, 32'h7F, 50);
    repeat (40) @(posedge i_clock);
    rd_chk(32'(REG_STATUS), 32'h01, 32'h7F);
    bus(1'b1, 32'(REG_CTRL), 32'h3, 1'b0);
    wait_state(32'h02, 32'h7F, 100);
    hot <= 1'b1;
    wait_state(32'hC0, 32'hFF, 20);
    complete_run();
  end

  initial begin
    repeat (40000) @(posedge i_clock);
    mismatches++;
    complete_run();
  end
endmodule : bisq_sequencer_test
